/* File: hw/sfsc_params.svh */
// Purpose: offsets, field positions, reset values and counts for the supply fault block
// Assumes: included by bare name from package or module
// Notes: register indices are word indices, byte address is four times the index
`ifndef SFSC_PARAMS_SVH
`define SFSC_PARAMS_SVH

`define SFSC_IDX_STATUS   16'h00F9
`define SFSC_IDX_CTRL     16'h28B2
`define SFSC_IDX_IOCFG    16'h2704
`define SFSC_IDX_NVRAM    16'h2710
`define SFSC_IDX_VOLRAM   16'h2711

`define SFSC_BIT_SLEEP    7
`define SFSC_BIT_MISSION  1
`define SFSC_BIT_EXT_RAM  0
`define SFSC_BIT_CONV_EN  4

`define SFSC_RST_CTRL     8'h00
`define SFSC_RST_IOCFG    8'h00
`define SFSC_RST_NVRAM    8'h00
`define SFSC_RST_VOLRAM   8'h00
// idle flag levels, order xtal, pll, core min, core good, present, warn
`define SFSC_RST_SYNC     6'h0E

`define SFSC_CODE_GOOD    3'h0
`define SFSC_CODE_LOW     3'h1
`define SFSC_CODE_BATT    3'h2
`define SFSC_CODE_WEAK    3'h3
`define SFSC_CODE_DEAD    3'h5

`define SFSC_COLLAPSE_TICKS 3'h4

`endif

/* File: hw/sfsc_pkg.sv */
// Purpose: types shared by the supply fault and sleep control block
// Assumes: APB with 32-bit data and 16-bit byte address
// Notes: constants live in sfsc_params.svh
package sfsc_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } sfsc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sfsc_apb_rsp_t;

   typedef enum logic [1:0] {
      ST_BOOT,
      ST_MISSION,
      ST_SLEEP,
      ST_WAKE
   } sfsc_mode_t;

endpackage

/* File: hw/sfsc_top.sv */
// Purpose: power mode sequencing and supply fault status for the metering core
// Assumes: comparator flags are asynchronous; crystal clock is sampled as a level
// Notes: one clock, synchronous active-high reset, CE freezes all state
//
// Functional notes
// - with supply present and pll locked, run in mission mode
// - without system supply, stay in low power mode
// - supply below warning threshold gives code 001, operation continues
// - supply restore returns to mission mode with no software action
// - sleep is left only by system power-up
// - io configuration and nv data are kept through sleep
// - sleep bit with supply present still sleeps, drops wake, then wakes
// - after wake processor restarts at zero, external ram invalid, io ram partial
// - nv io ram survives wake, cleared only by reset
// - warning threshold only changes the code, nothing else
// - lower threshold switches to battery while memories still work
// - above lower threshold always switch back to system supply
// - codes 000 good, 001 low, 010 core good on battery
// - code 011 weak core, flash writes blocked
// - code 101 forces reset after four crystal clock cycles
// - status code is read-only at index f9 bits 2:0
// - interrupt on every status code change
// - supply below lower threshold stops converter clocks
// - stopping converter leaves stored enable bit unchanged
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "sfsc_params.svh"

module sfsc_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire sfsc_pkg::sfsc_apb_req_t APB_REQ,
   output sfsc_pkg::sfsc_apb_rsp_t APB_RSP,
   input wire logic ANALOG_SUPPLY_WARNING_FLAG,
   input wire logic MAIN_SUPPLY_PRESENT_FLAG,
   input wire logic CORE_SUPPLY_GOOD,
   input wire logic CORE_SUPPLY_MIN,
   input wire logic PLL_LOCK,
   input wire logic CRYSTAL_CLOCK_32K,
   output logic MISSION_MODE,
   output logic LOW_POWER_MODE,
   output logic WAKE,
   output logic BATTERY_SEL,
   output logic DIGITAL_SUPPLY_EN,
   output logic CONV_CLK_EN,
   output logic FLASH_WR_EN,
   output logic CPU_RST,
   output logic EXT_RAM_VALID,
   output logic STATUS_IRQ
);
   import sfsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers; stage one feeds stage two only
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic [5:0] raw_in;
   logic warn_s, present_s, core_good_s, core_min_s, pll_s, xtal_s;

   assign raw_in = {CRYSTAL_CLOCK_32K, PLL_LOCK, CORE_SUPPLY_MIN, CORE_SUPPLY_GOOD,
                    MAIN_SUPPLY_PRESENT_FLAG, ANALOG_SUPPLY_WARNING_FLAG};

   always_ff @(posedge CLK) begin
      if (RST) begin
         // idle levels, so no false supply loss or code change follows reset
         sync1_ff <= `SFSC_RST_SYNC;
         sync2_ff <= `SFSC_RST_SYNC;
      end else if (CE) begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
      end
   end

   assign warn_s = sync2_ff[0];
   assign present_s = sync2_ff[1];
   assign core_good_s = sync2_ff[2];
   assign core_min_s = sync2_ff[3];
   assign pll_s = sync2_ff[4];
   assign xtal_s = sync2_ff[5];

   ////////////////////////////////////////////////////////////////////////////
   // status code, change pulse, collapse counter
   logic [2:0] code_ff, nxt_code;
   logic irq_ff, nxt_irq;
   logic xtal_d_ff, nxt_xtal_d;
   logic [2:0] tick_ff, nxt_tick;
   logic collapse_ff, nxt_collapse;
   logic xtal_rise;

   assign xtal_rise = xtal_s & ~xtal_d_ff;

   always_comb begin
      if (present_s && !warn_s) begin
         nxt_code = `SFSC_CODE_GOOD;
      end else if (present_s) begin
         nxt_code = `SFSC_CODE_LOW;
      end else if (core_good_s) begin
         nxt_code = `SFSC_CODE_BATT;
      end else if (core_min_s) begin
         nxt_code = `SFSC_CODE_WEAK;
      end else begin
         nxt_code = `SFSC_CODE_DEAD;
      end
      nxt_irq = (nxt_code != code_ff);
      nxt_xtal_d = xtal_s;
      nxt_tick = tick_ff;
      nxt_collapse = collapse_ff;
      if (code_ff != `SFSC_CODE_DEAD) begin
         nxt_tick = 3'h0;
         nxt_collapse = 1'b0;
      end else if (xtal_rise && tick_ff != `SFSC_COLLAPSE_TICKS) begin
         nxt_tick = tick_ff + 3'h1;
         nxt_collapse = (tick_ff + 3'h1 == `SFSC_COLLAPSE_TICKS);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         code_ff <= `SFSC_CODE_GOOD;
         irq_ff <= 1'b0;
         xtal_d_ff <= 1'b0;
         tick_ff <= 3'h0;
         collapse_ff <= 1'b0;
      end else if (CE) begin
         code_ff <= nxt_code;
         irq_ff <= nxt_irq;
         xtal_d_ff <= nxt_xtal_d;
         tick_ff <= nxt_tick;
         collapse_ff <= nxt_collapse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file and apb slave
   // access phase takes two cycles: pready rises one edge after penable
   logic sleep_req_ff, nxt_sleep_req;
   logic ext_ram_ok_ff, nxt_ext_ram_ok;
   logic [7:0] iocfg_ff, nxt_iocfg;
   logic [7:0] nvram_ff, nxt_nvram;
   logic [7:0] volram_ff, nxt_volram;
   sfsc_apb_rsp_t rsp_ff, nxt_rsp;
   sfsc_mode_t mode_ff, nxt_mode;
   logic access, wr, hit;
   logic [15:0] idx;
   logic enter_sleep, wake_done;

   assign access = APB_REQ.psel & APB_REQ.penable & ~rsp_ff.pready;
   assign wr = access & APB_REQ.pwrite;
   assign idx = {2'b00, APB_REQ.paddr[15:2]};
   assign enter_sleep = (mode_ff != ST_SLEEP) && (nxt_mode == ST_SLEEP);
   assign wake_done = (mode_ff == ST_WAKE) && (nxt_mode == ST_MISSION);

   always_comb begin
      nxt_sleep_req = sleep_req_ff;
      nxt_ext_ram_ok = ext_ram_ok_ff;
      nxt_iocfg = iocfg_ff;
      nxt_nvram = nvram_ff;
      nxt_volram = volram_ff;
      nxt_rsp = '0;
      hit = 1'b1;
      // hardware clear on sleep entry first, so a same-cycle write wins
      if (enter_sleep) begin
         nxt_sleep_req = 1'b0;
         nxt_ext_ram_ok = 1'b0;
      end
      if (wake_done) begin
         // a request stored while asleep is stale once power is back
         nxt_sleep_req = 1'b0;
         nxt_volram = `SFSC_RST_VOLRAM;
      end
      case (idx)
         `SFSC_IDX_STATUS: begin
            nxt_rsp.prdata = {29'h0000_0000, code_ff};
         end
         `SFSC_IDX_CTRL: begin
            nxt_rsp.prdata = {24'h00_0000, sleep_req_ff, 5'h00,
                              mode_ff == ST_MISSION, ext_ram_ok_ff};
            if (wr && APB_REQ.pwdata[`SFSC_BIT_SLEEP]) begin
               nxt_sleep_req = 1'b1;
            end
            if (wr && APB_REQ.pwdata[`SFSC_BIT_EXT_RAM]) begin
               nxt_ext_ram_ok = 1'b1;
            end
         end
         `SFSC_IDX_IOCFG: begin
            nxt_rsp.prdata = {24'h00_0000, iocfg_ff};
            if (wr) begin
               nxt_iocfg = APB_REQ.pwdata[7:0];
            end
         end
         `SFSC_IDX_NVRAM: begin
            nxt_rsp.prdata = {24'h00_0000, nvram_ff};
            if (wr) begin
               nxt_nvram = APB_REQ.pwdata[7:0];
            end
         end
         `SFSC_IDX_VOLRAM: begin
            nxt_rsp.prdata = {24'h00_0000, volram_ff};
            if (wr) begin
               nxt_volram = APB_REQ.pwdata[7:0];
            end
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      if (!access) begin
         nxt_rsp = '0;
      end else begin
         nxt_rsp.pready = 1'b1;
         nxt_rsp.pslverr = ~hit;
      end
   end

   // nv and io config registers see only RST, never the wake path
   always_ff @(posedge CLK) begin
      if (RST) begin
         sleep_req_ff <= 1'b0;
         ext_ram_ok_ff <= 1'b0;
         iocfg_ff <= `SFSC_RST_IOCFG;
         nvram_ff <= `SFSC_RST_NVRAM;
         volram_ff <= `SFSC_RST_VOLRAM;
         rsp_ff <= '0;
      end else if (CE) begin
         sleep_req_ff <= nxt_sleep_req;
         ext_ram_ok_ff <= nxt_ext_ram_ok;
         iocfg_ff <= nxt_iocfg;
         nvram_ff <= nxt_nvram;
         volram_ff <= nxt_volram;
         rsp_ff <= nxt_rsp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencer
   // supply loss enters sleep in hardware, dropping digital supply and converter clock
   logic mission_ff, sleep_ff, wake_ff, batt_ff, dsup_ff, conv_ff, flash_ff, cpu_rst_ff;
   logic nxt_mission, nxt_sleep, nxt_wake, nxt_batt, nxt_dsup, nxt_conv, nxt_flash;
   logic nxt_cpu_rst;

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         ST_BOOT: begin
            if (!present_s) begin
               nxt_mode = ST_SLEEP;
            end else if (pll_s) begin
               nxt_mode = ST_MISSION;
            end
         end
         ST_MISSION: begin
            if (!present_s || sleep_req_ff) begin
               nxt_mode = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // only a power-up leaves sleep; register writes have no path here
            if (present_s) begin
               nxt_mode = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (!present_s) begin
               nxt_mode = ST_SLEEP;
            end else if (pll_s) begin
               nxt_mode = ST_MISSION;
            end
         end
         default: begin
            nxt_mode = ST_BOOT;
         end
      endcase
      nxt_mission = (nxt_mode == ST_MISSION);
      nxt_sleep = (nxt_mode == ST_SLEEP);
      nxt_wake = (nxt_mode != ST_SLEEP);
      nxt_dsup = (nxt_mode != ST_SLEEP);
      nxt_batt = ~present_s;
      // the stored enable bit is untouched, only the gate drops
      nxt_conv = iocfg_ff[`SFSC_BIT_CONV_EN] & present_s & nxt_mission;
      nxt_flash = (nxt_code != `SFSC_CODE_WEAK) && (nxt_code != `SFSC_CODE_DEAD);
      // processor held in reset until mission so it restarts at address zero
      nxt_cpu_rst = !nxt_mission || nxt_collapse;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         mode_ff <= ST_BOOT;
         mission_ff <= 1'b0;
         sleep_ff <= 1'b0;
         wake_ff <= 1'b1;
         batt_ff <= 1'b0;
         dsup_ff <= 1'b1;
         conv_ff <= 1'b0;
         flash_ff <= 1'b1;
         cpu_rst_ff <= 1'b1;
      end else if (CE) begin
         mode_ff <= nxt_mode;
         mission_ff <= nxt_mission;
         sleep_ff <= nxt_sleep;
         wake_ff <= nxt_wake;
         batt_ff <= nxt_batt;
         dsup_ff <= nxt_dsup;
         conv_ff <= nxt_conv;
         flash_ff <= nxt_flash;
         cpu_rst_ff <= nxt_cpu_rst;
      end
   end

   assign APB_RSP = rsp_ff;
   assign MISSION_MODE = mission_ff;
   assign LOW_POWER_MODE = sleep_ff;
   assign WAKE = wake_ff;
   assign BATTERY_SEL = batt_ff;
   assign DIGITAL_SUPPLY_EN = dsup_ff;
   assign CONV_CLK_EN = conv_ff;
   assign FLASH_WR_EN = flash_ff;
   assign CPU_RST = cpu_rst_ff;
   assign EXT_RAM_VALID = ext_ram_ok_ff;
   assign STATUS_IRQ = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST || !CE);

   sequence mission_stable_s;
      mode_ff == ST_MISSION && present_s && !sleep_req_ff;
   endsequence

   sequence sleep_then_wake_s;
      mode_ff == ST_SLEEP ##1 mode_ff == ST_WAKE;
   endsequence

   mission_entry_a: assert property (
      (mode_ff == ST_WAKE && present_s && pll_s) |=> MISSION_MODE && !CPU_RST)
      else $error("wake with pll lock did not reach mission");

   sleep_entry_a: assert property (
      (mode_ff == ST_MISSION && !present_s) |=> LOW_POWER_MODE && !WAKE && !DIGITAL_SUPPLY_EN)
      else $error("supply loss did not enter sleep");

   sleep_req_a: assert property (
      (mode_ff == ST_MISSION && sleep_req_ff) |=> mode_ff == ST_SLEEP && !sleep_req_ff)
      else $error("sleep request not honoured");

   wake_path_a: assert property (sleep_then_wake_s |-> $past(present_s))
      else $error("sleep left without supply");

   forced_sleep_a: assert property (
      (mode_ff == ST_MISSION && sleep_req_ff && present_s) |=> sleep_then_wake_s)
      else $error("sleep with supply present did not wake");

   code_low_a: assert property ((present_s && warn_s) |=> code_ff == 3'h1)
      else $error("warning code not shown");

   code_map_a: assert property (
      (!present_s && !core_good_s && core_min_s) |=> !FLASH_WR_EN)
      else $error("flash write not blocked at weak core");

   irq_pulse_a: assert property ((code_ff != $past(code_ff)) |-> STATUS_IRQ)
      else $error("code change without interrupt");

   irq_single_a: assert property (STATUS_IRQ |=> !STATUS_IRQ || $changed(code_ff))
      else $error("duplicate interrupt for one change");

   collapse_rst_a: assert property (
      (tick_ff == 3'h3 && xtal_rise && code_ff == `SFSC_CODE_DEAD) |=> collapse_ff ##1 CPU_RST)
      else $error("no reset after four crystal cycles");

   collapse_early_a: assert property (
      (code_ff == `SFSC_CODE_DEAD && tick_ff != `SFSC_COLLAPSE_TICKS) |-> !collapse_ff)
      else $error("reset forced before four crystal cycles");

   conv_stop_a: assert property (
      !present_s |=> !CONV_CLK_EN && (iocfg_ff == $past(iocfg_ff) || $past(wr)))
      else $error("converter clock not stopped");

   batt_sel_a: assert property (mission_stable_s |=> !BATTERY_SEL)
      else $error("battery kept with supply present");

   status_ro_a: assert property (
      (wr && idx == `SFSC_IDX_STATUS && nxt_code == code_ff) |=> $stable(code_ff) && !STATUS_IRQ)
      else $error("status code altered by write");

endmodule // sfsc_top

/* File: sim/tb.sv */
// Purpose: self-checking bench for the supply fault and sleep control block
// Assumes: apb slave answers after the first access edge; flags are synchronised inside
// Notes: clock enable is dropped once to show the freeze; settling uses fixed margins
`timescale 1ns/1ps
`include "sfsc_params.svh"

module tb;
   import sfsc_pkg::*;

   logic clk, rst, ce, warn, present, core_good, core_min, pll, xtal;
   sfsc_apb_req_t req;
   sfsc_apb_rsp_t rsp;
   logic mission, low_power, wake, batt, dig_en, conv_en, flash_en, cpu_rst, ext_ram_ok, irq;
   integer miscompares = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer irq_n = 0;
   logic saw_sleep, saw_wake_low;

   sfsc_top u_sfsc_top (.CLK(clk), .RST(rst), .CE(ce), .APB_REQ(req), .APB_RSP(rsp),
      .ANALOG_SUPPLY_WARNING_FLAG(warn), .MAIN_SUPPLY_PRESENT_FLAG(present),
      .CORE_SUPPLY_GOOD(core_good), .CORE_SUPPLY_MIN(core_min), .PLL_LOCK(pll),
      .CRYSTAL_CLOCK_32K(xtal), .MISSION_MODE(mission), .LOW_POWER_MODE(low_power),
      .WAKE(wake), .BATTERY_SEL(batt), .DIGITAL_SUPPLY_EN(dig_en), .CONV_CLK_EN(conv_en),
      .FLASH_WR_EN(flash_en), .CPU_RST(cpu_rst), .EXT_RAM_VALID(ext_ram_ok), .STATUS_IRQ(irq));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulse and sleep watchers; one-cycle outputs are only seen here
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (irq === 1'b1) irq_n <= irq_n + 1;
      if (low_power === 1'b1) saw_sleep <= 1'b1;
      if (wake === 1'b0) saw_wake_low <= 1'b1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task summarize();
      if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task check1(input logic seen, input logic exp);
      check({31'h0000_0000, seen}, {31'h0000_0000, exp});
   endtask

   task step(input integer n);
      repeat (n) @(posedge clk);
   endtask

   // one apb transfer; a free edge first keeps back-to-back calls from double driving
   task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
      integer n;
      @(posedge clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= {idx[13:0], 2'b00};
      req.pwdata <= wd;
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) miscompares = miscompares + 1;
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, idx, d, rd, err);
   endtask

   task rdchk(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, idx, 32'h0000_0000, rd, err);
      check(rd, exp);
   endtask

   task code_is(input logic [2:0] c);
      rdchk(`SFSC_IDX_STATUS, {29'h0000_0000, c});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task t_boot();
      check1(mission, 1'b0);
      present <= 1'b1;
      core_good <= 1'b1;
      core_min <= 1'b1;
      pll <= 1'b1;
      step(10);
      check1(mission, 1'b1);
      check1(cpu_rst, 1'b0);
      check1(batt, 1'b0);
      check1(dig_en, 1'b1);
      code_is(`SFSC_CODE_GOOD);
   endtask

   task t_regs();
      logic [31:0] rd;
      logic err;
      integer base;
      wr(`SFSC_IDX_IOCFG, 32'h0000_0010);
      wr(`SFSC_IDX_NVRAM, 32'h0000_00A5);
      wr(`SFSC_IDX_STATUS, 32'h0000_0007);
      code_is(`SFSC_CODE_GOOD);
      apb(1'b0, 16'h0010, 32'h0000_0000, rd, err);
      check1(err, 1'b1);
      step(2);
      check1(conv_en, 1'b1);
      // with the clock enable low a supply loss must not be seen at all
      base = irq_n;
      ce <= 1'b0;
      present <= 1'b0;
      step(6);
      ce <= 1'b1;
      present <= 1'b1;
      step(6);
      check1(low_power, 1'b0);
      check1(mission, 1'b1);
      check(irq_n - base, 0);
   endtask

   // warning, battery, weak, dead, then restore; one pulse per code change
   task t_fall_and_restore();
      integer base;
      base = irq_n;
      warn <= 1'b1;
      step(8);
      code_is(`SFSC_CODE_LOW);
      check1(mission, 1'b1);
      check1(conv_en, 1'b1);
      check1(dig_en, 1'b1);
      check(irq_n - base, 1);
      present <= 1'b0;
      step(8);
      code_is(`SFSC_CODE_BATT);
      check1(batt, 1'b1);
      check1(flash_en, 1'b1);
      check1(low_power, 1'b1);
      check1(conv_en, 1'b0);
      check1(dig_en, 1'b0);
      // firmware sets the sleep bit below the lower threshold and pokes the mission bit
      wr(`SFSC_IDX_CTRL, 32'h0000_0082);
      step(4);
      check1(mission, 1'b0);
      core_good <= 1'b0;
      step(8);
      code_is(`SFSC_CODE_WEAK);
      check1(flash_en, 1'b0);
      core_min <= 1'b0;
      step(8);
      code_is(`SFSC_CODE_DEAD);
      check1(flash_en, 1'b0);
      repeat (5) begin
         xtal <= 1'b1;
         step(4);
         xtal <= 1'b0;
         step(4);
      end
      check1(cpu_rst, 1'b1);
      check(irq_n - base, 4);
      rdchk(`SFSC_IDX_IOCFG, 32'h0000_0010);
      rdchk(`SFSC_IDX_NVRAM, 32'h0000_00A5);
      warn <= 1'b0;
      present <= 1'b1;
      core_good <= 1'b1;
      core_min <= 1'b1;
      step(12);
      check(irq_n - base, 5);
      check1(mission, 1'b1);
      check1(batt, 1'b0);
      check1(flash_en, 1'b1);
      check1(ext_ram_ok, 1'b0);
      check1(conv_en, 1'b1);
      rdchk(`SFSC_IDX_CTRL, 32'h0000_0002);
      rdchk(`SFSC_IDX_NVRAM, 32'h0000_00A5);
   endtask

   // sleep bit with supply present: sleep, drop wake, come back on its own
   task t_forced_sleep();
      wr(`SFSC_IDX_CTRL, 32'h0000_0001);
      wr(`SFSC_IDX_VOLRAM, 32'h0000_003C);
      step(2);
      check1(ext_ram_ok, 1'b1);
      saw_sleep = 1'b0;
      saw_wake_low = 1'b0;
      wr(`SFSC_IDX_CTRL, 32'h0000_0080);
      step(12);
      check1(saw_sleep, 1'b1);
      check1(saw_wake_low, 1'b1);
      check1(mission, 1'b1);
      check1(cpu_rst, 1'b0);
      check1(ext_ram_ok, 1'b0);
      rdchk(`SFSC_IDX_CTRL, 32'h0000_0002);
      rdchk(`SFSC_IDX_VOLRAM, 32'h0000_0000);
      rdchk(`SFSC_IDX_NVRAM, 32'h0000_00A5);
      rdchk(`SFSC_IDX_IOCFG, 32'h0000_0010);
      rst <= 1'b1;
      step(2);
      rst <= 1'b0;
      rdchk(`SFSC_IDX_NVRAM, 32'h0000_0000);
      check1(mission, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      warn = 1'b0;
      present = 1'b1;
      core_good = 1'b1;
      core_min = 1'b1;
      pll = 1'b0;
      xtal = 1'b0;
      req = '0;
      saw_sleep = 1'b0;
      saw_wake_low = 1'b0;
      step(6);
      rst <= 1'b0;
      step(1);
      t_boot();
      t_regs();
      t_fall_and_restore();
      t_forced_sleep();
      summarize();
   end
endmodule // tb
